// *** design/system_clock_sleep_control.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"

module system_clock_sleep_control (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  supply_above_hi,
    input  wire logic                  supply_below_lo,
    input  wire logic                  io_wake,
    input  wire logic                  rtc_wake,
    output clk_ctrl_pkg::clk_out_s     clk_out,
    output logic                       line_power_flag,
    output clk_ctrl_pkg::power_state_e power_state
);

    // ==========================================================
    // Input synchronisers
    logic [3:0] sync1;
    logic [3:0] sync2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {rtc_wake, io_wake, supply_below_lo, supply_above_hi};
            sync2 <= sync1;
        end
    end

    logic above_s;
    logic below_s;
    logic io_s;
    logic rtc_s;

    assign above_s = sync2[0];
    assign below_s = sync2[1];
    assign io_s    = sync2[2];
    assign rtc_s   = sync2[3];

    // ==========================================================
    // Line power flag with hysteresis between the two thresholds
    logic line_power_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_power_flag <= 1'b0;
        end else if (above_s) begin
            line_power_flag <= 1'b1;
        end else if (below_s) begin
            line_power_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_power_q <= 1'b0;
        end else begin
            line_power_q <= line_power_flag;
        end
    end

    logic power_return;

    assign power_return = line_power_flag & ~line_power_q;

    // ==========================================================
    // APB slave
    logic                    addr_hit;
    logic                    wr_en;
    clk_ctrl_pkg::ctrl_reg_s ctrl;
    clk_ctrl_pkg::ctrl_reg_s wdat;

    assign addr_hit = (paddr == `CSC_ADDR);
    assign wr_en    = psel & penable & pwrite & addr_hit;
    assign wdat     = clk_ctrl_pkg::ctrl_reg_s'(pwdata[`CSC_WIDTH-1:0]);
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~addr_hit;

    // Read data is captured in the setup cycle so the access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= addr_hit ? {24'h0, ctrl} : 32'h0;
        end
    end

    // ==========================================================
    // Sleep state machine
    logic fsc_accept;
    logic fwc_accept;
    logic field_sleep;
    logic wake_evt;

    assign fwc_accept  = wr_en & ~ctrl.fast_sleep_cmd & ~wdat.fast_sleep_cmd;
    assign fsc_accept  = wr_en & wdat.fast_sleep_cmd;
    assign field_sleep = wr_en & ~line_power_flag & ~ctrl.cpu_clk_src_sel
                         & (wdat.sleep_field != `SLEEP_NONE);

    always_comb begin
        case (power_state)
            clk_ctrl_pkg::ST_SLEEP: wake_evt = io_s | rtc_s | power_return;
            clk_ctrl_pkg::ST_DEEP:  wake_evt = io_s | power_return;
            default:                wake_evt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state <= clk_ctrl_pkg::ST_RUN;
        end else begin
            case (power_state)
                clk_ctrl_pkg::ST_RUN: begin
                    if (fsc_accept && !line_power_flag) begin
                        power_state <= clk_ctrl_pkg::ST_SLEEP;
                    end else if (field_sleep) begin
                        if (wdat.sleep_field == `SLEEP_DEEP) begin
                            power_state <= clk_ctrl_pkg::ST_DEEP;
                        end else begin
                            power_state <= clk_ctrl_pkg::ST_SLEEP;
                        end
                    end
                end
                clk_ctrl_pkg::ST_SLEEP,
                clk_ctrl_pkg::ST_DEEP: begin
                    if (wake_evt) begin
                        power_state <= clk_ctrl_pkg::ST_RUN;
                    end
                end
                default: begin
                    power_state <= clk_ctrl_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Control register
    // The lock freezes source and gate bits, except that fast-sleep and PLL-wake writes still set the CPU source; the sleep bits stay writable
    // so firmware can still enter a low-power state while locked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= clk_ctrl_pkg::ctrl_reg_s'(`CSC_RESET);
        end else if (wake_evt) begin
            ctrl.sleep_field    <= `SLEEP_NONE;
            ctrl.pll_wake_lock  <= 1'b0;
            ctrl.fast_sleep_cmd <= 1'b0;
        end else if (wr_en) begin
            if (!ctrl.pll_wake_lock) begin
                ctrl.metering_clk_src_sel <= wdat.metering_clk_src_sel;
                ctrl.metering_clk_gate    <= wdat.metering_clk_gate;
                ctrl.display_clk_gate     <= wdat.display_clk_gate;
                ctrl.cpu_clk_src_sel      <= wdat.cpu_clk_src_sel;
            end
            if (fwc_accept) begin
                ctrl.pll_wake_lock <= wdat.pll_wake_lock;
                if (wdat.pll_wake_lock) begin
                    ctrl.cpu_clk_src_sel <= 1'b1;
                end
            end
            ctrl.fast_sleep_cmd <= wdat.fast_sleep_cmd;
            if (wdat.fast_sleep_cmd) begin
                ctrl.cpu_clk_src_sel <= 1'b0;
            end
            ctrl.sleep_field <= wdat.sleep_field;
        end
    end

    // ==========================================================
    // PLL run request
    logic pll_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_on <= 1'b0;
        end else if (fsc_accept) begin
            pll_on <= 1'b0;
        end else if (fwc_accept && wdat.pll_wake_lock) begin
            pll_on <= 1'b1;
        end
    end

    // ==========================================================
    // Clock controls, registered so the clock tree sees clean levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out <= '{default: 1'b0};
        end else begin
            clk_out.cpu_clk_src       <= ctrl.cpu_clk_src_sel;
            clk_out.metering_clk_src  <= ctrl.metering_clk_src_sel;
            clk_out.pll_enable        <= pll_on;
            clk_out.cpu_clock_en      <= (power_state == clk_ctrl_pkg::ST_RUN)
                                         & ~ctrl.fast_sleep_cmd;
            clk_out.fourth_clock_en   <= (power_state == clk_ctrl_pkg::ST_RUN);
            clk_out.metering_clock_en <= ~ctrl.metering_clk_gate;
            clk_out.display_clock_en  <= ~(ctrl.display_clk_gate & ctrl.cpu_clk_src_sel
                                           & ctrl.metering_clk_src_sel);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_met_src_follows;
        clk_out.metering_clk_src == $past(ctrl.metering_clk_src_sel);
    endproperty
    a_met_src_follows: assert property (p_met_src_follows) else $error("metering source mismatch");

    property p_fwc_ignored;
        wr_en && ctrl.fast_sleep_cmd && !wake_evt |=> $stable(ctrl.pll_wake_lock) && !pll_on;
    endproperty
    a_fwc_ignored: assert property (p_fwc_ignored) else $error("lock bit changed during fast sleep");

    property p_fwc_start;
        fwc_accept && wdat.pll_wake_lock |=> pll_on && ctrl.cpu_clk_src_sel ##1 clk_out.cpu_clk_src;
    endproperty
    a_fwc_start: assert property (p_fwc_start) else $error("PLL wake did not switch CPU clock");

    property p_lock_holds;
        wr_en && ctrl.pll_wake_lock && !wdat.fast_sleep_cmd && !wake_evt
            |=> $stable(ctrl.metering_clk_src_sel) && $stable(ctrl.metering_clk_gate);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked settings changed");

    property p_fsc_stop;
        fsc_accept && power_state == clk_ctrl_pkg::ST_RUN
            |=> !pll_on && !ctrl.cpu_clk_src_sel ##1 !clk_out.cpu_clock_en && !clk_out.cpu_clk_src;
    endproperty
    a_fsc_stop: assert property (p_fsc_stop) else $error("fast sleep did not stop CPU clock");

    property p_fsc_sleep;
        fsc_accept && power_state == clk_ctrl_pkg::ST_RUN
            |=> power_state == ($past(line_power_flag) ? clk_ctrl_pkg::ST_RUN : clk_ctrl_pkg::ST_SLEEP);
    endproperty
    a_fsc_sleep: assert property (p_fsc_sleep) else $error("fast sleep entered wrong state");

    property p_met_gate;
        ctrl.metering_clk_gate [*2] |-> !clk_out.metering_clock_en;
    endproperty
    a_met_gate: assert property (p_met_gate) else $error("metering clock not gated");

    property p_disp_gate;
        !(ctrl.cpu_clk_src_sel && ctrl.metering_clk_src_sel) |=> clk_out.display_clock_en;
    endproperty
    a_disp_gate: assert property (p_disp_gate) else $error("display clock stopped without PLL");

    property p_field_sleep;
        field_sleep && !fsc_accept && power_state == clk_ctrl_pkg::ST_RUN
            && wdat.sleep_field[0] |=> power_state == clk_ctrl_pkg::ST_SLEEP ##1 !clk_out.fourth_clock_en;
    endproperty
    a_field_sleep: assert property (p_field_sleep) else $error("sleep code did not enter Sleep");

    property p_deep;
        field_sleep && !fsc_accept && power_state == clk_ctrl_pkg::ST_RUN
            && wdat.sleep_field == `SLEEP_DEEP |=> power_state == clk_ctrl_pkg::ST_DEEP;
    endproperty
    a_deep: assert property (p_deep) else $error("sleep code 10 did not enter Deep Sleep");

    property p_no_sleep_on_pll;
        wr_en && ctrl.cpu_clk_src_sel && !wdat.fast_sleep_cmd && power_state == clk_ctrl_pkg::ST_RUN
            |=> power_state == clk_ctrl_pkg::ST_RUN;
    endproperty
    a_no_sleep_on_pll: assert property (p_no_sleep_on_pll) else $error("sleep entered with PLL CPU clock");

    property p_cpu_src_follows;
        clk_out.cpu_clk_src == $past(ctrl.cpu_clk_src_sel);
    endproperty
    a_cpu_src_follows: assert property (p_cpu_src_follows) else $error("CPU source mismatch");

    property p_wake_clear;
        wake_evt |=> power_state == clk_ctrl_pkg::ST_RUN && ctrl.sleep_field == `SLEEP_NONE
            && !ctrl.fast_sleep_cmd && !ctrl.pll_wake_lock && $stable(ctrl.metering_clk_gate);
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup did not clear sleep bits");

    property p_line_power;
        above_s |=> line_power_flag;
    endproperty
    a_line_power: assert property (p_line_power) else $error("line power flag not set");

    property p_battery;
        below_s && !above_s |=> !line_power_flag;
    endproperty
    a_battery: assert property (p_battery) else $error("line power flag not cleared");

    property p_read_shows;
        psel && !penable && !pwrite && addr_hit |=> prdata == {24'h0, $past(ctrl)};
    endproperty
    a_read_shows: assert property (p_read_shows) else $error("read data differs from register");

    property p_unlock_keeps;
        fwc_accept && ctrl.pll_wake_lock && !wdat.pll_wake_lock && !wake_evt
            |=> !ctrl.pll_wake_lock && $stable(ctrl.cpu_clk_src_sel) && $stable(ctrl.metering_clk_src_sel);
    endproperty
    a_unlock_keeps: assert property (p_unlock_keeps) else $error("unlock switched a clock source");

    property p_fsc_pll_off;
        ctrl.fast_sleep_cmd |-> !pll_on;
    endproperty
    a_fsc_pll_off: assert property (p_fsc_pll_off) else $error("PLL running during fast sleep");

    property p_line_no_sleep;
        fsc_accept && line_power_flag && power_state == clk_ctrl_pkg::ST_RUN |=> power_state == clk_ctrl_pkg::ST_RUN;
    endproperty
    a_line_no_sleep: assert property (p_line_no_sleep) else $error("fast sleep entered on line power");

    property p_met_run;
        !ctrl.metering_clk_gate |=> clk_out.metering_clock_en;
    endproperty
    a_met_run: assert property (p_met_run) else $error("metering clock stopped while ungated");

    property p_disp_stop;
        ctrl.display_clk_gate && ctrl.cpu_clk_src_sel && ctrl.metering_clk_src_sel |=> !clk_out.display_clock_en;
    endproperty
    a_disp_stop: assert property (p_disp_stop) else $error("display clock not stopped");

    property p_sleep_clocks_off;
        power_state != clk_ctrl_pkg::ST_RUN |=> !clk_out.cpu_clock_en && !clk_out.fourth_clock_en;
    endproperty
    a_sleep_clocks_off: assert property (p_sleep_clocks_off) else $error("CPU clock running in sleep");

    property p_deep_holds;
        power_state == clk_ctrl_pkg::ST_DEEP && !io_s && !power_return |=> power_state == clk_ctrl_pkg::ST_DEEP;
    endproperty
    a_deep_holds: assert property (p_deep_holds) else $error("Deep Sleep left without a valid wakeup");

    property p_wake_keeps;
        wake_evt |=> $stable(ctrl.metering_clk_src_sel) && $stable(ctrl.display_clk_gate)
            && $stable(ctrl.cpu_clk_src_sel);
    endproperty
    a_wake_keeps: assert property (p_wake_keeps) else $error("wakeup changed preserved bits");

endmodule

// *** design/clk_ctrl_defines.svh ***
// Functional notes
// - Bit 7 selects metering clock source, 0 oscillator, 1 PLL; reads show it.
// - The PLL-wake-and-lock bit acts only while fast-sleep reads zero.
// - Writing one to PLL-wake-and-lock starts the PLL and moves CPU clock to it.
// - Writing one locks clock settings; writing zero unlocks without switching sources.
// - Fast-sleep moves CPU clock to oscillator, stops PLL, then stops CPU clock; the code changes all three outputs on one edge.
// - Fast-sleep enters Sleep, never Deep Sleep, only when line power is absent.
// - Bit 4 stops the metering clock when set; resets to zero, clock running.
// - Bit 3 stops display clock only while PLL feeds CPU and metering clocks.
// - On battery with CPU select zero, sleep codes 11 or 01 enter Sleep.
// - Same preconditions, sleep code 10 stops CPU and fourth clocks, enters Deep Sleep.
// - Bit 0 selects CPU clock source, 0 oscillator, 1 PLL; reads show it.
// - Wakeup without reset keeps state but clears sleep field, lock and fast-sleep bits.
// - Line-power flag is one above 1.1 V, zero below 1.0 V.
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

// ==========================================================
// Register map
`define CSC_ADDR        12'h080
`define CSC_RESET       8'h00
`define CSC_WIDTH       8

// ==========================================================
// Sleep field codes
`define SLEEP_NONE      2'b00
`define SLEEP_LIGHT_A   2'b01
`define SLEEP_DEEP      2'b10
`define SLEEP_LIGHT_B   2'b11

`endif

// *** design/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;

    // Field order matches the register bits 7 down to 0
    typedef struct packed {
        logic       metering_clk_src_sel;
        logic       pll_wake_lock;
        logic       fast_sleep_cmd;
        logic       metering_clk_gate;
        logic       display_clk_gate;
        logic [1:0] sleep_field;
        logic       cpu_clk_src_sel;
    } ctrl_reg_s;

    typedef struct packed {
        logic cpu_clk_src;
        logic metering_clk_src;
        logic pll_enable;
        logic cpu_clock_en;
        logic fourth_clock_en;
        logic metering_clock_en;
        logic display_clock_en;
    } clk_out_s;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_DEEP  = 2'b10
    } power_state_e;

endpackage

// *** verification/system_clock_sleep_control_bench.sv ***
`timescale 1ns/1ps
module system_clock_sleep_control_bench;
    localparam logic [11:0] A = 12'h080;
    logic                      pclk;
    logic                      presetn;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      supply_above_hi;
    logic                      supply_below_lo;
    logic                      io_wake;
    logic                      rtc_wake;
    clk_ctrl_pkg::clk_out_s     clk_out;
    logic                      line_power_flag;
    clk_ctrl_pkg::power_state_e power_state;
    int                        n_mismatch;
    int                        total_checks;
    logic [31:0]               d;
    logic                      e;

    system_clock_sleep_control u_system_clock_sleep_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_above_hi(supply_above_hi),
        .supply_below_lo(supply_below_lo), .io_wake(io_wake), .rtc_wake(rtc_wake),
        .clk_out(clk_out), .line_power_flag(line_power_flag), .power_state(power_state)
    );

    // ==========================================
    // Helpers
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is sampled high; only the watchdog ends a hang
    task automatic hs(output logic [31:0] rdata, output logic err);
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        hs(d, e);
    endtask

    task automatic rc(input logic [7:0] exp);
        xfer(1'b0, A, 8'h00);
        check(d, {24'h0, exp});
    endtask

    // Outputs follow a write one edge later; sample clear of the edge
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic set_supply(input logic hi);
        @(posedge pclk);
        supply_above_hi <= hi;
        supply_below_lo <= !hi;
        repeat (6) @(posedge pclk);
        #1;
        check({31'h0, line_power_flag}, {31'h0, hi});
    endtask

    task automatic wake(input logic use_rtc);
        @(posedge pclk);
        if (use_rtc) rtc_wake <= 1'b1;
        else io_wake <= 1'b1;
        repeat (4) @(posedge pclk);
        rtc_wake <= 1'b0;
        io_wake <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
    endtask

    function automatic logic [31:0] ps(input clk_ctrl_pkg::power_state_e s);
        return {30'h0, s};
    endfunction

    // ==========================================
    // Scenarios
    task automatic t_reset;
        settle();
        check({25'h0, clk_out}, 32'h0000000f);
        rc(8'h00);
        xfer(1'b0, 12'h084, 8'h00);
        check({31'h0, e}, 32'h1);
        check(d, 32'h0);
        xfer(1'b1, 12'h084, 8'hff);
        rc(8'h00);
    endtask

    task automatic t_sources;
        xfer(1'b1, A, 8'h81);
        settle();
        rc(8'h81);
        check({31'h0, clk_out.cpu_clk_src}, 32'h1);
        check({31'h0, clk_out.metering_clk_src}, 32'h1);
        xfer(1'b1, A, 8'h01);
        settle();
        check({31'h0, clk_out.metering_clk_src}, 32'h0);
        xfer(1'b1, A, 8'h80);
        settle();
        check({31'h0, clk_out.cpu_clk_src}, 32'h0);
        xfer(1'b1, A, 8'h10);
        settle();
        check({31'h0, clk_out.metering_clock_en}, 32'h0);
        xfer(1'b1, A, 8'h09);
        settle();
        check({31'h0, clk_out.display_clock_en}, 32'h1);
        xfer(1'b1, A, 8'h89);
        settle();
        check({31'h0, clk_out.display_clock_en}, 32'h0);
        xfer(1'b1, A, 8'h00);
    endtask

    task automatic t_lock;
        xfer(1'b1, A, 8'h40);
        settle();
        rc(8'h41);
        check({31'h0, clk_out.pll_enable}, 32'h1);
        check({31'h0, clk_out.cpu_clk_src}, 32'h1);
        xfer(1'b1, A, 8'hd8);
        rc(8'h41);
        xfer(1'b1, A, 8'h00);
        settle();
        rc(8'h01);
        check({31'h0, clk_out.cpu_clk_src}, 32'h1);
    endtask

    // Line power present: fast sleep stops the CPU clock but stays in run
    task automatic t_fast_line;
        xfer(1'b1, A, 8'h20);
        settle();
        rc(8'h20);
        check({28'h0, clk_out.cpu_clk_src, clk_out.pll_enable, clk_out.cpu_clock_en, 1'b0}, 32'h0);
        check(ps(power_state), ps(clk_ctrl_pkg::ST_RUN));
        xfer(1'b1, A, 8'h60);
        settle();
        rc(8'h20);
        check({31'h0, clk_out.pll_enable}, 32'h0);
        xfer(1'b1, A, 8'h00);
    endtask

    task automatic t_sleep;
        logic [1:0] c;
        set_supply(1'b0);
        xfer(1'b1, A, 8'h01);
        xfer(1'b1, A, 8'h03);
        settle();
        check(ps(power_state), ps(clk_ctrl_pkg::ST_RUN));
        rc(8'h03);
        xfer(1'b1, A, 8'h00);
        for (int k = 1; k < 4; k++) begin
            c = k[1:0];
            xfer(1'b1, A, {5'b00010, c, 1'b0});
            settle();
            check(ps(power_state), ps(c == 2'b10 ? clk_ctrl_pkg::ST_DEEP : clk_ctrl_pkg::ST_SLEEP));
            check({30'h0, clk_out.cpu_clock_en, clk_out.fourth_clock_en}, 32'h0);
            if (c == 2'b10) begin
                wake(1'b1);
                check(ps(power_state), ps(clk_ctrl_pkg::ST_DEEP));
            end
            wake(c == 2'b01);
            check(ps(power_state), ps(clk_ctrl_pkg::ST_RUN));
            check({31'h0, clk_out.cpu_clock_en}, 32'h1);
            rc(8'h10);
        end
        xfer(1'b1, A, 8'h30);
        settle();
        check(ps(power_state), ps(clk_ctrl_pkg::ST_SLEEP));
        wake(1'b0);
        rc(8'h10);
        xfer(1'b1, A, 8'h04);
        settle();
        check(ps(power_state), ps(clk_ctrl_pkg::ST_DEEP));
        set_supply(1'b1);
        check(ps(power_state), ps(clk_ctrl_pkg::ST_RUN));
        rc(8'h00);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, io_wake, rtc_wake} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        supply_above_hi = 1'b1;
        supply_below_lo = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        set_supply(1'b1);
        t_sources();
        t_lock();
        t_fast_line();
        t_sleep();
        conclude();
    end

    // Whole run is a few hundred cycles; this bound cuts a hang short
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule
